/* pkg/tsd_map.vh */
`ifndef TSD_MAP_VH
`define TSD_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TSD_OFF_CMD     4'h0
`define TSD_OFF_STAT    4'h4
`define TSD_OFF_RESULT  4'h8

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define TSD_F_OP_LO     0
`define TSD_F_OUT_LO    4
`define TSD_F_ARG_LO    8
`define TSD_F_IDX_LO    16
`define TSD_F_QUAL_LO   21
`define TSD_F_SLOT_LO   24

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define TSD_OP_STD_SET  4'h0
`define TSD_OP_STD_Q    4'h1
`define TSD_OP_SIG_SET  4'h2
`define TSD_OP_SIG_Q    4'h3
`define TSD_OP_BLK_SET  4'h4
`define TSD_OP_BLK_Q    4'h5
`define TSD_OP_PER_SET  4'h6
`define TSD_OP_PER_Q    4'h7
`define TSD_OP_TXT_SET  4'h8
`define TSD_OP_TXT_Q    4'h9
`define TSD_OP_DAT_SET  4'hA
`define TSD_OP_DAT_Q    4'hB
`define TSD_OP_LOAD     4'hC
`define TSD_OP_ACT_Q    4'hD

// ----------------------------------------------------------------------
// Query qualifiers
// ----------------------------------------------------------------------
`define TSD_Q_CUR       2'h0
`define TSD_Q_MIN       2'h1
`define TSD_Q_MAX       2'h2
`define TSD_Q_DEF       2'h3

// ----------------------------------------------------------------------
// Standards and signal codes
// ----------------------------------------------------------------------
`define TSD_STD_NTSC    2'h0
`define TSD_STD_NTSC_NS 2'h1
`define TSD_STD_PAL     2'h2
`define TSD_SIG_BB      5'h00
`define TSD_SIG_BLACK_BURST_WITH_FIELD_REF 5'h01
`define TSD_SIG_BB_NOFR 5'h02
`define TSD_SIG_LAST12  5'h09
`define TSD_SIG_FIRST4  5'h0A
`define TSD_SIG_LAST    5'h11

// ----------------------------------------------------------------------
// Blink period in half seconds, reset values, text size
// ----------------------------------------------------------------------
`define TSD_PER_HALF    2'h1
`define TSD_PER_ONE     2'h2
`define TSD_PER_DEF     2'h1
`define TSD_TEXT_MAX    5'h12
`define TSD_RESP_OKAY   2'h0
`define TSD_RESP_SLVERR 2'h2

`endif

/* src/tsd_decoder.v */
// Summary of operation
// R1: One standard kept per output 1, 2, 4.
// R2: Standard and signal commands accept indices 1,2,4.
// R3: Outputs 1,2 offer the ten timing signals.
// R4: Output 4 offers bars, field, user signals.
// R5: Blink enable per output 3 and 4.
// R6: Boolean argument 1 means on, 0 off.
// R7: Blink interval only half or one second.
// R8: Overlay enable per output 3 and 4.
// R9: Overlay text holds at most eighteen characters.
// R10: Signal and standard queries return current values.
// R11: Interval query returns the stored interval.
// R12: Load signal by slot; active query returns it.
// R13: Min, max, default qualifiers return limits. Here only the interval query takes them; every other command rejects them.
// R14: Bad index or selection rejected, state unchanged.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "tsd_map.vh"

module tsd_decoder #(
	parameter [3:0] SLOT_NUM = 4'h1
) (
	// Clock and reset
	input  wire         mclk,
	input  wire         resetn,
	// AXI4-Lite write address
	input  wire         s_axi_awvalid,
	output wire         s_axi_awready,
	input  wire [3:0]   s_axi_awaddr,
	// AXI4-Lite write data
	input  wire         s_axi_wvalid,
	output wire         s_axi_wready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	// AXI4-Lite write response
	output wire         s_axi_bvalid,
	input  wire         s_axi_bready,
	output wire [1:0]   s_axi_bresp,
	// AXI4-Lite read address
	input  wire         s_axi_arvalid,
	output wire         s_axi_arready,
	input  wire [3:0]   s_axi_araddr,
	// AXI4-Lite read data
	output wire         s_axi_rvalid,
	input  wire         s_axi_rready,
	output wire [31:0]  s_axi_rdata,
	output wire [1:0]   s_axi_rresp,
	// Settings for outputs 1, 2 and 4, lowest slice is output 1
	output wire [5:0]   std_out,
	output wire [14:0]  sig_out,
	// Overlay settings for outputs 3 and 4, bit 0 is output 3
	output wire [1:0]   blink_en,
	output wire [3:0]   blink_period,
	output wire [1:0]   text_en,
	output wire [9:0]   text_len,
	output wire [287:0] text_chars,
	// Signal loaded into this module
	output wire [4:0]   active_sig
);

	// ------------------------------------------------------------------
	// Bus slave state
	// ------------------------------------------------------------------
	reg         aw_full_reg;
	reg         w_full_reg;
	reg  [3:0]  aw_addr_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         bvalid_reg;
	reg  [1:0]  bresp_reg;
	reg         rvalid_reg;
	reg  [31:0] rdata_reg;
	reg  [1:0]  rresp_reg;

	// ------------------------------------------------------------------
	// Block state
	// ------------------------------------------------------------------
	reg  [1:0]  std_reg [0:2];
	reg  [4:0]  sig_reg [0:2];
	reg  [1:0]  blink_reg;
	reg  [1:0]  per_reg [0:1];
	reg  [1:0]  text_reg;
	reg  [4:0]  len_reg [0:1];
	reg  [7:0]  txt_mem [0:35];
	reg  [4:0]  act_reg;
	reg  [31:0] result_reg;
	reg         acc_reg;
	reg         rej_reg;
	reg  [7:0]  cnt_reg;

	wire        wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire        cmd_hit = wr_fire & (aw_addr_reg == `TSD_OFF_CMD) &
	                      (w_strb_reg == 4'hF);
	wire [3:0]  op   = w_data_reg[`TSD_F_OP_LO +: 4];
	wire [2:0]  outn = w_data_reg[`TSD_F_OUT_LO +: 3];
	wire [7:0]  arg  = w_data_reg[`TSD_F_ARG_LO +: 8];
	wire [4:0]  cidx = w_data_reg[`TSD_F_IDX_LO +: 5];
	wire [1:0]  qual = w_data_reg[`TSD_F_QUAL_LO +: 2];
	wire [3:0]  slot = w_data_reg[`TSD_F_SLOT_LO +: 4];

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	reg         vid_ok;
	reg  [1:0]  vs;
	reg         ovl_ok;
	reg         os;
	reg         sig_ok;
	reg         ok;
	reg  [31:0] res;
	reg  [5:0]  mi;

	always @* begin
		vid_ok = 1'b1;
		vs     = 2'h0;
		case (outn) // see R2
			3'h1: vs = 2'h0;
			3'h2: vs = 2'h1;
			3'h4: vs = 2'h2;
			default: vid_ok = 1'b0;
		endcase
		ovl_ok = (outn == 3'h3) | (outn == 3'h4);
		os     = (outn == 3'h4);
		if (vs == 2'h2) begin // see R4
			sig_ok = (arg[7:5] == 3'h0) &
			         ((arg[4:0] <= `TSD_SIG_BB_NOFR) |
			          ((arg[4:0] >= `TSD_SIG_FIRST4) &
			           (arg[4:0] <= `TSD_SIG_LAST)));
		end else begin // see R3
			sig_ok = (arg <= {3'h0, `TSD_SIG_LAST12});
		end
		mi  = os ? {1'b0, cidx} + 6'h12 : {1'b0, cidx};
		ok  = 1'b0;
		res = 32'h0;
		case (op)
			`TSD_OP_STD_SET: ok = vid_ok & (arg <= 8'h02); // see R1, R14
			`TSD_OP_STD_Q: begin
				ok  = vid_ok;
				res = {30'h0, std_reg[vs]}; // see R10
			end
			`TSD_OP_SIG_SET: ok = vid_ok & sig_ok; // see R14
			`TSD_OP_SIG_Q: begin
				ok  = vid_ok;
				res = {27'h0, sig_reg[vs]}; // see R10
			end
			`TSD_OP_BLK_SET: ok = ovl_ok & (arg <= 8'h01); // see R6, R14
			`TSD_OP_BLK_Q: begin
				ok  = ovl_ok;
				res = {31'h0, blink_reg[os]}; // see R5
			end
			`TSD_OP_PER_SET: begin // see R7
				ok = ovl_ok & ((arg == 8'h01) | (arg == 8'h02));
			end
			`TSD_OP_PER_Q: begin
				ok = ovl_ok;
				case (qual) // see R13
					`TSD_Q_MIN: res = {30'h0, `TSD_PER_HALF};
					`TSD_Q_MAX: res = {30'h0, `TSD_PER_ONE};
					`TSD_Q_DEF: res = {30'h0, `TSD_PER_DEF};
					default:    res = {30'h0, per_reg[os]}; // see R11
				endcase
			end
			`TSD_OP_TXT_SET: ok = ovl_ok & (arg <= 8'h01); // see R6, R8
			`TSD_OP_TXT_Q: begin
				ok  = ovl_ok;
				res = {31'h0, text_reg[os]}; // see R8
			end
			`TSD_OP_DAT_SET: ok = ovl_ok & (cidx < `TSD_TEXT_MAX); // see R9
			`TSD_OP_DAT_Q: begin
				ok  = ovl_ok & (cidx < `TSD_TEXT_MAX);
				res = {19'h0, len_reg[os], txt_mem[mi]};
			end
			`TSD_OP_LOAD: begin // see R12
				ok = (slot == SLOT_NUM) & (arg <= {3'h0, `TSD_SIG_LAST});
			end
			`TSD_OP_ACT_Q: begin
				ok  = (slot == SLOT_NUM);
				res = {27'h0, act_reg}; // see R12
			end
			default: ok = 1'b0;
		endcase
		// Limit qualifiers exist only on the interval query.
		if ((qual != `TSD_Q_CUR) && (op != `TSD_OP_PER_Q)) begin
			ok = 1'b0; // see R13
		end
	end

	// ------------------------------------------------------------------
	// Setting registers
	// ------------------------------------------------------------------
	integer i;
	always @(posedge mclk) begin
		if (!resetn) begin
			for (i = 0; i < 3; i = i + 1) begin
				std_reg[i] <= `TSD_STD_NTSC;
				sig_reg[i] <= `TSD_SIG_BB;
			end
			for (i = 0; i < 36; i = i + 1) begin
				txt_mem[i] <= 8'h00;
			end
			per_reg[0] <= `TSD_PER_DEF;
			per_reg[1] <= `TSD_PER_DEF;
			len_reg[0] <= 5'h00;
			len_reg[1] <= 5'h00;
			blink_reg  <= 2'h0;
			text_reg   <= 2'h0;
			act_reg    <= `TSD_SIG_BB;
			result_reg <= 32'h0;
			acc_reg    <= 1'b0;
			rej_reg    <= 1'b0;
			cnt_reg    <= 8'h00;
		end else if (cmd_hit) begin
			acc_reg <= ok;
			rej_reg <= ~ok; // see R14
			cnt_reg <= cnt_reg + 8'h01;
			if (ok) begin
				result_reg <= res;
				case (op)
					`TSD_OP_STD_SET: std_reg[vs] <= arg[1:0]; // see R1
					`TSD_OP_SIG_SET: sig_reg[vs] <= arg[4:0];
					`TSD_OP_BLK_SET: blink_reg[os] <= arg[0]; // see R5
					`TSD_OP_PER_SET: per_reg[os] <= arg[1:0]; // see R7
					`TSD_OP_TXT_SET: text_reg[os] <= arg[0]; // see R8
					`TSD_OP_DAT_SET: begin
						// A zero character ends the string at its index.
						txt_mem[mi] <= arg;
						if (arg == 8'h00) begin
							len_reg[os] <= cidx;
						end else if (cidx >= len_reg[os]) begin
							len_reg[os] <= cidx + 5'h01; // see R9
						end
					end
					`TSD_OP_LOAD: act_reg <= arg[4:0]; // see R12
					default: act_reg <= act_reg;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	always @(posedge mclk) begin
		if (!resetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `TSD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				// Only the command word is writable, and only whole.
				bresp_reg   <= cmd_hit ? `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always @(posedge mclk) begin
		if (!resetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= `TSD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= `TSD_RESP_OKAY;
			case (s_axi_araddr)
				`TSD_OFF_CMD:    rdata_reg <= w_data_reg;
				`TSD_OFF_STAT:   rdata_reg <= {22'h0, cnt_reg, rej_reg,
				                               acc_reg};
				`TSD_OFF_RESULT: rdata_reg <= result_reg;
				default: begin
					rdata_reg <= 32'h0;
					rresp_reg <= `TSD_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Settings towards the video generators
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_vid
			assign std_out[2*g +: 2] = std_reg[g];
			assign sig_out[5*g +: 5] = sig_reg[g];
		end
		for (g = 0; g < 2; g = g + 1) begin : g_ovl
			assign blink_period[2*g +: 2] = per_reg[g];
			assign text_len[5*g +: 5]     = len_reg[g];
		end
		for (g = 0; g < 36; g = g + 1) begin : g_txt
			assign text_chars[8*g +: 8] = txt_mem[g];
		end
	endgenerate

	assign blink_en   = blink_reg;
	assign text_en    = text_reg;
	assign active_sig = act_reg;

endmodule

/* test/tb_test_signal_output_command_decoder.sv */
`include "tsd_map.vh"
module tb_test_signal_output_command_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, hung;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, blink_period;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, blink_en, text_en, r;
	logic [5:0]  std_out, sm;
	logic [14:0] sig_out, gm;
	logic [9:0]  text_len;
	logic [287:0] text_chars;
	logic [4:0]  active_sig;
	logic [33:0] exp_q[$], msk_q[$];
	int          mismatches = 0, checked = 0, i, c, s;
	tsd_decoder #(.SLOT_NUM(4'h1)) tsd_decoder_i (.*);
	tsd_host tsd_host_i (.*);
	always #5 mclk = ~mclk;
	task automatic chk(input logic [33:0] v, input logic [33:0] e);
		checked++;
		if (v !== e) begin
			mismatches++;
			$display("MISMATCH %0t: got %h expected %h", $time, v, e);
		end
	endtask
	task end_sim;
		// A read answer that never arrived is a failure as well.
		if (exp_q.size() != 0) mismatches++;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		wait (hung);
		mismatches++;
		end_sim;
	end
	always @(posedge mclk) if (s_axi_rvalid && s_axi_rready) begin
		if (exp_q.size() == 0) chk(34'h0, 34'h1);
		else chk({s_axi_rresp, s_axi_rdata} & msk_q.pop_front(), exp_q.pop_front());
	end
	function logic [31:0] cw(input logic [3:0] op, input logic [2:0] n,
		input logic [7:0] a, input logic [4:0] x = 5'h0,
		input logic [1:0] q = 2'h0, input logic [3:0] sl = 4'h0);
		return {4'h0, sl, 1'b0, q, x, a, 1'b0, n, op};
	endfunction
	// Writes one command, then reads back the accept and reject flags.
	task go(input logic [31:0] w, input logic ok);
		tsd_host_i.wr(`TSD_OFF_CMD, w, 4'hF, r);
		chk({32'h0, r}, {32'h0, `TSD_RESP_OKAY});
		exp_q.push_back({32'h0, !ok, ok});
		msk_q.push_back({2'h3, 30'h0, 2'h3});
		tsd_host_i.rd(`TSD_OFF_STAT, d, r);
	endtask
	task res(input logic [31:0] e);
		exp_q.push_back({2'h0, e});
		msk_q.push_back('1);
		tsd_host_i.rd(`TSD_OFF_RESULT, d, r);
	endtask
	initial begin
		void'($urandom(89683));
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk({std_out, sig_out, blink_en, blink_period, text_en, active_sig},
			{21'h0, 2'h0, `TSD_PER_DEF, `TSD_PER_DEF, 7'h0});
		chk({24'h0, text_len}, 34'h0);
		$display("reset test done");
		sm = 6'h0;
		for (i = 0; i < 3; i++) begin
			s = $urandom % 3;
			sm[i*2 +: 2] = s[1:0];
			go(cw(`TSD_OP_STD_SET, (i == 2) ? 3'h4 : 3'(i + 1), 8'(s)), 1'b1);
			chk({28'h0, std_out}, {28'h0, sm});
			go(cw(`TSD_OP_STD_Q, (i == 2) ? 3'h4 : 3'(i + 1), 8'h0), 1'b1);
			res(32'(s));
		end
		go(cw(`TSD_OP_STD_SET, 3'h3, 8'h0), 1'b0);
		go(cw(`TSD_OP_STD_SET, 3'h1, 8'h3), 1'b0);
		go(cw(`TSD_OP_STD_Q, 3'h1, 8'h0, 5'h0, `TSD_Q_MAX), 1'b0);
		chk({28'h0, std_out}, {28'h0, sm});
		$display("standard test done");
		gm = 15'h0;
		for (c = 0; c < 18; c++) begin
			go(cw(`TSD_OP_SIG_SET, 3'h1, 8'(c)), c <= 9);
			if (c <= 9) gm[4:0] = 5'(c);
			go(cw(`TSD_OP_SIG_SET, 3'h4, 8'(c)), c <= 2 || c >= 10);
			if (c <= 2 || c >= 10) gm[14:10] = 5'(c);
			chk({19'h0, sig_out}, {19'h0, gm});
		end
		go(cw(`TSD_OP_SIG_SET, 3'h2, 8'h8), 1'b1);
		go(cw(`TSD_OP_SIG_SET, 3'h3, 8'h0), 1'b0);
		chk({19'h0, sig_out}, {19'h0, gm[14:10], 5'h8, gm[4:0]});
		go(cw(`TSD_OP_SIG_Q, 3'h4, 8'h0), 1'b1);
		res(32'd17);
		$display("signal test done");
		for (i = 0; i < 2; i++) begin
			go(cw(`TSD_OP_BLK_SET, 3'(i + 3), 8'h1), 1'b1);
			chk({32'h0, blink_en}, {32'h0, i ? 2'h3 : 2'h1});
			go(cw(`TSD_OP_BLK_Q, 3'(i + 3), 8'h0), 1'b1);
			res(32'h1);
		end
		go(cw(`TSD_OP_BLK_SET, 3'h3, 8'h0), 1'b1);
		go(cw(`TSD_OP_BLK_SET, 3'h4, 8'h2), 1'b0);
		chk({32'h0, blink_en}, {32'h0, 2'h2});
		go(cw(`TSD_OP_PER_SET, 3'h3, {6'h0, `TSD_PER_ONE}), 1'b1);
		go(cw(`TSD_OP_PER_SET, 3'h4, 8'h3), 1'b0);
		chk({30'h0, blink_period}, {30'h0, `TSD_PER_HALF, `TSD_PER_ONE});
		go(cw(`TSD_OP_PER_Q, 3'h3, 8'h0), 1'b1);
		res({30'h0, `TSD_PER_ONE});
		for (i = 1; i < 4; i++) begin
			go(cw(`TSD_OP_PER_Q, 3'h3, 8'h0, 5'h0, 2'(i)), 1'b1);
			res({30'h0, (i == 2) ? `TSD_PER_ONE : `TSD_PER_HALF});
		end
		$display("blink test done");
		go(cw(`TSD_OP_TXT_SET, 3'h4, 8'h1), 1'b1);
		chk({32'h0, text_en}, {32'h0, 2'h2});
		go(cw(`TSD_OP_TXT_Q, 3'h4, 8'h0), 1'b1);
		res(32'h1);
		s = $urandom % 95 + 32;
		go(cw(`TSD_OP_DAT_SET, 3'h3, 8'(s), 5'd17), 1'b1);
		go(cw(`TSD_OP_DAT_SET, 3'h3, 8'h41, 5'd18), 1'b0);
		chk({24'h0, text_len}, {29'h0, `TSD_TEXT_MAX});
		go(cw(`TSD_OP_DAT_Q, 3'h3, 8'h0, 5'd17), 1'b1);
		res({19'h0, `TSD_TEXT_MAX, 8'(s)});
		go(cw(`TSD_OP_DAT_SET, 3'h4, 8'h41, 5'd0), 1'b1);
		go(cw(`TSD_OP_DAT_SET, 3'h3, 8'h00, 5'd5), 1'b1);
		chk({26'h0, text_chars[8*17 +: 8]}, {26'h0, 8'(s)});
		chk({26'h0, text_chars[8*18 +: 8]}, 34'h41);
		chk({24'h0, text_len}, {24'h0, 5'h01, 5'h05});
		$display("text test done");
		go(cw(`TSD_OP_LOAD, 3'h0, 8'h5, 5'h0, 2'h0, 4'h1), 1'b1);
		go(cw(`TSD_OP_LOAD, 3'h0, 8'h7, 5'h0, 2'h0, 4'h2), 1'b0);
		chk({29'h0, active_sig}, 34'h5);
		go(cw(`TSD_OP_ACT_Q, 3'h0, 8'h0, 5'h0, 2'h0, 4'h1), 1'b1);
		res(32'h5);
		$display("load test done");
		tsd_host_i.wr(4'hC, 32'h0, 4'hF, r);
		chk({32'h0, r}, {32'h0, `TSD_RESP_SLVERR});
		tsd_host_i.wr(`TSD_OFF_CMD, cw(`TSD_OP_STD_SET, 3'h1, 8'h2), 4'h3, r);
		chk({32'h0, r}, {32'h0, `TSD_RESP_SLVERR});
		chk({28'h0, std_out}, {28'h0, sm});
		exp_q.push_back({`TSD_RESP_SLVERR, 32'h0});
		msk_q.push_back('1);
		tsd_host_i.rd(4'hC, d, r);
		$display("bus test done");
		// Reset is held three edges so the quiet check never sees a step.
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk({std_out, sig_out, blink_en, blink_period, text_en, active_sig},
			{21'h0, 2'h0, `TSD_PER_DEF, `TSD_PER_DEF, 7'h0});
		chk({24'h0, text_len}, 34'h0);
		exp_q.push_back(34'h0);
		msk_q.push_back('1);
		tsd_host_i.rd(`TSD_OFF_STAT, d, r);
		repeat (2) @(posedge mclk);
		$display("second reset test done");
		end_sim;
	end
endmodule

bind tsd_decoder tsd_decoder_sva tsd_decoder_sva_i (.*);

/* test/tsd_decoder_sva.sv */
`include "tsd_map.vh"
module tsd_decoder_sva (
	input wire        mclk,
	input wire        resetn,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [5:0]  std_out,
	input wire [14:0] sig_out,
	input wire [1:0]  blink_en,
	input wire [3:0]  blink_period,
	input wire [1:0]  text_en,
	input wire [9:0]  text_len,
	input wire [4:0]  active_sig
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_std_code: assert property (std_out[1:0] != 2'h3 && std_out[3:2] != 2'h3
		&& std_out[5:4] != 2'h3) else $error("illegal standard code");
	a_sig_black: assert property (sig_out[4:0] <= `TSD_SIG_LAST12
		&& sig_out[9:5] <= `TSD_SIG_LAST12) else $error("bad black signal");
	a_sig_bars: assert property (sig_out[14:10] <= `TSD_SIG_BB_NOFR
		|| (sig_out[14:10] >= `TSD_SIG_FIRST4 && sig_out[14:10] <= `TSD_SIG_LAST))
		else $error("bad bars signal");
	a_period_two: assert property (blink_period[1:0] inside {2'h1, 2'h2}
		&& blink_period[3:2] inside {2'h1, 2'h2}) else $error("bad period");
	a_text_max: assert property (text_len[4:0] <= `TSD_TEXT_MAX
		&& text_len[9:5] <= `TSD_TEXT_MAX) else $error("text too long");
	a_set_quiet: assert property (!$rose(s_axi_bvalid) |-> $stable({std_out,
		sig_out, blink_en, blink_period, text_en, text_len, active_sig}))
		else $error("setting changed without a command");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_wresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready
		&& !s_axi_wready) else $error("write taken while busy");
	cover property ($rose(blink_en[0]));
	cover property ($changed(active_sig));
	cover property (text_len[4:0] == `TSD_TEXT_MAX);
endmodule

/* test/tsd_host.sv */
module tsd_host (
	input  wire logic        mclk,
	output logic             s_axi_awvalid,
	output logic [3:0]       s_axi_awaddr,
	output logic             s_axi_wvalid,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_bready,
	output logic             s_axi_arvalid,
	output logic [3:0]       s_axi_araddr,
	output logic             s_axi_rready,
	output logic             hung,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, hung, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_wstrb} = '0;
	end
	// Addresses and write data are inverted once taken (the strobes are not), so a slave that samples them late fails.
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid && n < 99);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
		if (n >= 99) hung <= 1'b1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid && n < 99);
		s_axi_rready <= 1'b0;
		{r, d} = {s_axi_rresp, s_axi_rdata};
		if (n >= 99) hung <= 1'b1;
	endtask
endmodule
